// ### hw/synth_bias_config_regs.v
// Notes on behaviour
// - Word B split high, mid, low bytes
// - Word B defaults 75, a5, 4e hex
// - Separation top three bits, reset zero
// - Separation low byte, reset 59 hex
// - Oscillator core bias bits 7:4, default 1100
// - Mixer buffer bias bits 3:2, default 10
// - Amplifier buffer bias bits 1:0, default 10
// - Follower bias bit 5; bits 7:6 unused
// - Input amplifier bias bits 4:3, default 01
// - Path select bits 2:1; code 11 decodes like 00
// - Bit 0 powers down crystal oscillator
// - Config reset low loads all defaults
// - Main select bit picks word A or B
`timescale 1ns/1ps
`include "synth_bias_regs.vh"

module synth_bias_config_regs (
  input  wire                 clk,
  input  wire                 resetn,
  input  wire                 ce,
  input  wire                 config_resetn,
  input  wire                 synth_word_select,
  input  wire [23:0]          synth_word_a,
  input  wire                 wr_en,
  input  wire [`ADDR_W-1:0]   wr_addr,
  input  wire [7:0]           wr_data,
  input  wire                 rd_en,
  input  wire [`ADDR_W-1:0]   rd_addr,
  output reg  [7:0]           rd_data,
  output reg                  rd_valid,
  output wire [23:0]          synth_word_b,
  output reg  [23:0]          synth_word_active,
  output wire [10:0]          tone_separation,
  output wire [3:0]           osc_core_bias,
  output wire [1:0]           mixer_buffer_bias,
  output wire [1:0]           amp_buffer_bias,
  output wire                 follower_bias,
  output wire [1:0]           input_amp_bias,
  output wire [1:0]           intermediate_path_select,
  output reg                  rssi_out_en,
  output reg                  mixer_out_ext,
  output reg                  internal_if_pd,
  output wire                 crystal_osc_skip
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  wire [7:0] word_b_high_q;
  wire [7:0] word_b_mid_q;
  wire [7:0] word_b_low_q;
  wire [7:0] tone_sep_high_q;
  wire [7:0] tone_sep_low_q;
  wire [7:0] bias_current_q;
  wire [7:0] receive_path_q;

  // Writes are blocked while the defaults are being forced
  wire       load_default = ~config_resetn;
  wire       wr_ok        = wr_en & config_resetn;

  cfg_byte_reg #(
    .RST_VAL (`RST_SYNTH_WORD_B_HIGH),
    .WR_MASK (`MASK_FULL)
  ) u_word_b_high (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .load_default (load_default),
    .wr_en        (wr_ok & (wr_addr == `OFF_SYNTH_WORD_B_HIGH)),
    .wr_data      (wr_data),
    .q            (word_b_high_q)
  );

  cfg_byte_reg #(
    .RST_VAL (`RST_SYNTH_WORD_B_MID),
    .WR_MASK (`MASK_FULL)
  ) u_word_b_mid (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .load_default (load_default),
    .wr_en        (wr_ok & (wr_addr == `OFF_SYNTH_WORD_B_MID)),
    .wr_data      (wr_data),
    .q            (word_b_mid_q)
  );

  cfg_byte_reg #(
    .RST_VAL (`RST_SYNTH_WORD_B_LOW),
    .WR_MASK (`MASK_FULL)
  ) u_word_b_low (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .load_default (load_default),
    .wr_en        (wr_ok & (wr_addr == `OFF_SYNTH_WORD_B_LOW)),
    .wr_data      (wr_data),
    .q            (word_b_low_q)
  );

  cfg_byte_reg #(
    .RST_VAL (`RST_TONE_SEP_HIGH),
    .WR_MASK (`MASK_TONE_SEP_HIGH)
  ) u_tone_sep_high (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .load_default (load_default),
    .wr_en        (wr_ok & (wr_addr == `OFF_TONE_SEP_HIGH)),
    .wr_data      (wr_data),
    .q            (tone_sep_high_q)
  );

  cfg_byte_reg #(
    .RST_VAL (`RST_TONE_SEP_LOW),
    .WR_MASK (`MASK_FULL)
  ) u_tone_sep_low (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .load_default (load_default),
    .wr_en        (wr_ok & (wr_addr == `OFF_TONE_SEP_LOW)),
    .wr_data      (wr_data),
    .q            (tone_sep_low_q)
  );

  cfg_byte_reg #(
    .RST_VAL (`RST_BIAS_CURRENT),
    .WR_MASK (`MASK_FULL)
  ) u_bias_current (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .load_default (load_default),
    .wr_en        (wr_ok & (wr_addr == `OFF_BIAS_CURRENT)),
    .wr_data      (wr_data),
    .q            (bias_current_q)
  );

  cfg_byte_reg #(
    .RST_VAL (`RST_RECEIVE_PATH),
    .WR_MASK (`MASK_RECEIVE_PATH)
  ) u_receive_path (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .load_default (load_default),
    .wr_en        (wr_ok & (wr_addr == `OFF_RECEIVE_PATH)),
    .wr_data      (wr_data),
    .q            (receive_path_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Field outputs to the analog side

  assign synth_word_b      = {word_b_high_q, word_b_mid_q, word_b_low_q};
  assign tone_separation   = {tone_sep_high_q[2:0], tone_sep_low_q};
  assign osc_core_bias     = bias_current_q[`OSC_CORE_BIAS_HI:`OSC_CORE_BIAS_LO];
  assign mixer_buffer_bias = bias_current_q[`MIXER_BUF_BIAS_HI:`MIXER_BUF_BIAS_LO];
  assign amp_buffer_bias   = bias_current_q[`AMP_BUF_BIAS_HI:`AMP_BUF_BIAS_LO];
  assign follower_bias     = receive_path_q[`FOLLOWER_BIAS_BIT];
  assign input_amp_bias    = receive_path_q[`INPUT_AMP_BIAS_HI:`INPUT_AMP_BIAS_LO];
  assign intermediate_path_select = receive_path_q[`PATH_SEL_HI:`PATH_SEL_LO];
  assign crystal_osc_skip  = receive_path_q[`CRYSTAL_SKIP_BIT];

  // Code 11 is not allowed; it is decoded like 00 so the IF strip stays safe
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      rssi_out_en    <= 1'b0;
      mixer_out_ext  <= 1'b0;
      internal_if_pd <= 1'b0;
    end
    else if (ce)
    begin
      rssi_out_en    <= (intermediate_path_select == `PATH_RSSI);
      mixer_out_ext  <= (intermediate_path_select == `PATH_EXTERNAL);
      internal_if_pd <= (intermediate_path_select == `PATH_EXTERNAL);
    end
  end

  // Registered so the synthesiser never sees a half-updated selection
  always @(posedge clk)
  begin
    if (!resetn)
      synth_word_active <= 24'h000000;
    else if (ce)
      synth_word_active <= synth_word_select ? synth_word_b : synth_word_a;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back

  reg [7:0] rd_mux;

  always @*
  begin
    case (rd_addr)
      `OFF_SYNTH_WORD_B_HIGH: rd_mux = word_b_high_q;
      `OFF_SYNTH_WORD_B_MID:  rd_mux = word_b_mid_q;
      `OFF_SYNTH_WORD_B_LOW:  rd_mux = word_b_low_q;
      `OFF_TONE_SEP_HIGH:     rd_mux = tone_sep_high_q;
      `OFF_TONE_SEP_LOW:      rd_mux = tone_sep_low_q;
      `OFF_BIAS_CURRENT:      rd_mux = bias_current_q;
      `OFF_RECEIVE_PATH:      rd_mux = receive_path_q;
      default:                rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= rd_mux;
    end
  end

endmodule // synth_bias_config_regs

// ### hw/synth_bias_regs.vh
`ifndef SYNTH_BIAS_REGS_VH
`define SYNTH_BIAS_REGS_VH

// Register offsets on the configuration port
`define ADDR_W                 7
`define OFF_SYNTH_WORD_B_HIGH  7'h04
`define OFF_SYNTH_WORD_B_MID   7'h05
`define OFF_SYNTH_WORD_B_LOW   7'h06
`define OFF_TONE_SEP_HIGH      7'h07
`define OFF_TONE_SEP_LOW       7'h08
`define OFF_BIAS_CURRENT       7'h09
`define OFF_RECEIVE_PATH       7'h0a

// Reset values
`define RST_SYNTH_WORD_B_HIGH  8'h75
`define RST_SYNTH_WORD_B_MID   8'ha5
`define RST_SYNTH_WORD_B_LOW   8'h4e
`define RST_TONE_SEP_HIGH      8'h00
`define RST_TONE_SEP_LOW       8'h59
`define RST_BIAS_CURRENT       8'hca
`define RST_RECEIVE_PATH       8'h08

// Writable bit masks
`define MASK_FULL              8'hff
`define MASK_TONE_SEP_HIGH     8'h07
`define MASK_RECEIVE_PATH      8'h3f

// Field positions
`define OSC_CORE_BIAS_HI       7
`define OSC_CORE_BIAS_LO       4
`define MIXER_BUF_BIAS_HI      3
`define MIXER_BUF_BIAS_LO      2
`define AMP_BUF_BIAS_HI        1
`define AMP_BUF_BIAS_LO        0
`define FOLLOWER_BIAS_BIT      5
`define INPUT_AMP_BIAS_HI      4
`define INPUT_AMP_BIAS_LO      3
`define PATH_SEL_HI            2
`define PATH_SEL_LO            1
`define CRYSTAL_SKIP_BIT       0

// Intermediate path select codes
`define PATH_INTERNAL          2'h0
`define PATH_RSSI              2'h1
`define PATH_EXTERNAL          2'h2

`endif

// ### hw/cfg_byte_reg.v
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter [7:0] RST_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hff
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       ce,
  input  wire       load_default,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  output wire [7:0] q
);

  reg [7:0] val_r;
  reg [7:0] val_nxt;

  always @*
  begin
    val_nxt = val_r;
    if (load_default)
      val_nxt = RST_VAL;
    else if (wr_en)
      val_nxt = wr_data & WR_MASK;
  end

  always @(posedge clk)
  begin
    if (!resetn)
      val_r <= RST_VAL;
    else if (ce)
      val_r <= val_nxt;
  end

  // Unused bits never store, so they read as zero
  assign q = val_r & WR_MASK;

endmodule // cfg_byte_reg

// ### test/synth_bias_asserts.sv
`timescale 1ns/1ps
module synth_bias_asserts (
  input wire        clk,
  input wire        resetn,
  input wire        ce,
  input wire        config_resetn,
  input wire        synth_word_select,
  input wire [23:0] synth_word_a,
  input wire        wr_en,
  input wire [6:0]  wr_addr,
  input wire [7:0]  wr_data,
  input wire        rd_en,
  input wire        rd_valid,
  input wire [23:0] synth_word_b,
  input wire [23:0] synth_word_active,
  input wire [10:0] tone_separation,
  input wire [3:0]  osc_core_bias,
  input wire [1:0]  mixer_buffer_bias,
  input wire [1:0]  amp_buffer_bias,
  input wire        follower_bias,
  input wire [1:0]  input_amp_bias,
  input wire [1:0]  intermediate_path_select,
  input wire        rssi_out_en,
  input wire        mixer_out_ext,
  input wire        internal_if_pd,
  input wire        crystal_osc_skip
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_dflt; ce && !config_resetn; endsequence
  sequence s_wr(a); ce && config_resetn && wr_en && wr_addr == a; endsequence
  a_rd_valid_pulse: assert property (ce && rd_en |=> rd_valid) else $error("read valid missing");
  a_word_b_dflt: assert property (s_dflt |=> synth_word_b == 24'h75a54e) else $error("word b default");
  a_tone_dflt: assert property (s_dflt |=> tone_separation == 11'h059) else $error("tone default");
  a_bias_dflt: assert property (s_dflt |=> {osc_core_bias, mixer_buffer_bias, amp_buffer_bias} == 8'hca)
    else $error("bias default");
  a_path_dflt: assert property (s_dflt |=> {follower_bias, input_amp_bias, intermediate_path_select,
    crystal_osc_skip} == 6'h08) else $error("path default");
  a_bias_write: assert property (s_wr(7'h09) |=> {osc_core_bias, mixer_buffer_bias, amp_buffer_bias}
    == $past(wr_data)) else $error("bias write");
  a_path_write: assert property (s_wr(7'h0a) |=> {follower_bias, input_amp_bias, intermediate_path_select,
    crystal_osc_skip} == $past(wr_data[5:0])) else $error("path write");
  a_word_low_write: assert property (s_wr(7'h06) |=> synth_word_b[7:0] == $past(wr_data))
    else $error("word low write");
  a_tone_high_write: assert property (s_wr(7'h07) |=> tone_separation[10:8] == $past(wr_data[2:0]))
    else $error("tone high write");
  a_path_decode: assert property (ce |=> rssi_out_en == ($past(intermediate_path_select) == 2'h1)
    && internal_if_pd == ($past(intermediate_path_select) == 2'h2)) else $error("path decode");
  a_word_select: assert property (ce |=> synth_word_active == ($past(synth_word_select) ?
    $past(synth_word_b) : $past(synth_word_a))) else $error("word select");
endmodule // synth_bias_asserts

bind synth_bias_config_regs synth_bias_asserts chk_u (.*);

// ### test/cfg_host.sv
`timescale 1ns/1ps
module cfg_host (
  input  wire       clk,
  input  wire [7:0] rd_data,
  input  wire       rd_valid,
  output reg        config_resetn,
  output reg        wr_en,
  output reg  [6:0] wr_addr,
  output reg  [7:0] wr_data,
  output reg        rd_en,
  output reg  [6:0] rd_addr
);
  initial {config_resetn, wr_en, wr_addr, wr_data, rd_en, rd_addr} = {1'b1, 1'b0, 7'h00, 8'h00, 1'b0, 7'h00};
  // Idle data shows the inverse so a stale byte never looks valid; writes any path code given, 11 included
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      wr_data <= ~d;
    end
  endtask
  task rd(input [6:0] a, output [7:0] d, output v);
    begin
      @(posedge clk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
      v = rd_valid;
    end
  endtask
  task cfg_rst(input val);
    begin
      @(posedge clk);
      config_resetn <= val;
    end
  endtask
endmodule // cfg_host

// ### test/transceiver_synth_bias_config_regs_tb.sv
`timescale 1ns/1ps
module transceiver_synth_bias_config_regs_tb;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         sel = 1'b0;
  reg         ce = 1'b1;
  reg  [23:0] word_a = 24'h3c5a69;
  wire        cfg_n, wr_en, rd_en, rd_valid, fol, rssi, mext, ifpd, xskip;
  wire [6:0]  wr_addr, rd_addr;
  wire [7:0]  wr_data, rd_data;
  wire [23:0] word_b, word_act;
  wire [10:0] tone;
  wire [3:0]  osc;
  wire [1:0]  mix, amp, lna, path;
  integer     fail_count = 0;
  integer     comparisons = 0;
  integer     i;
  reg  [7:0]  d;
  reg         v;
  synth_bias_config_regs dut_u (.clk(clk), .resetn(resetn), .ce(ce), .config_resetn(cfg_n),
    .synth_word_select(sel), .synth_word_a(word_a), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .synth_word_b(word_b),
    .synth_word_active(word_act), .tone_separation(tone), .osc_core_bias(osc), .mixer_buffer_bias(mix),
    .amp_buffer_bias(amp), .follower_bias(fol), .input_amp_bias(lna), .intermediate_path_select(path),
    .rssi_out_en(rssi), .mixer_out_ext(mext), .internal_if_pd(ifpd), .crystal_osc_skip(xskip));
  cfg_host host_u (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .config_resetn(cfg_n), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));
  initial forever #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task chk(input [31:0] e, input [31:0] s, input [8*12-1:0] nm);
    begin
      comparisons = comparisons + 1;
      if (e !== s)
      begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task rdchk(input [6:0] a, input [7:0] e);
    begin
      host_u.rd(a, d, v);
      chk({v, d}, {1'b1, e}, "readback");
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_defaults;
    begin
      rdchk(7'h04, 8'h75);
      rdchk(7'h05, 8'ha5);
      rdchk(7'h06, 8'h4e);
      rdchk(7'h07, 8'h00);
      rdchk(7'h08, 8'h59);
      rdchk(7'h09, 8'hca);
      rdchk(7'h0a, 8'h08);
    end
  endtask
  task t_write_all;
    begin
      for (i = 4; i <= 10; i = i + 1)
        host_u.wr(i[6:0], 8'hff);
      host_u.wr(7'h0b, 8'hff);
      rdchk(7'h07, 8'h07);
      rdchk(7'h0a, 8'h3f);
      rdchk(7'h0b, 8'h00);
      host_u.wr(7'h05, 8'h12);
      #1;
      chk(word_b, 24'hff12ff, "word_b");
      chk(tone, 11'h7ff, "tone");
    end
  endtask
  task t_bias;
    begin
      host_u.wr(7'h09, 8'h4d);
      #1;
      chk({osc, mix, amp}, {4'h4, 2'h3, 2'h1}, "bias");
    end
  endtask
  // Path outputs are one stage behind the field, hence the extra edge
  task t_path;
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        host_u.wr(7'h0a, {2'h0, 1'b1, 2'h2, i[1:0], 1'b1});
        @(posedge clk);
        #1;
        chk({fol, lna, path, xskip}, {1'b1, 2'h2, i[1:0], 1'b1}, "path");
        chk({rssi, mext, ifpd}, {i == 1, i == 2, i == 2}, "decode");
      end
    end
  endtask
  task t_cfg_reset;
    begin
      host_u.cfg_rst(1'b0);
      host_u.wr(7'h09, 8'h11);
      host_u.cfg_rst(1'b1);
      rdchk(7'h09, 8'hca);
      rdchk(7'h0a, 8'h08);
    end
  endtask
  // A write while the clock enable is low must be lost
  task t_hold;
    begin
      @(posedge clk);
      ce <= 1'b0;
      host_u.wr(7'h08, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      rdchk(7'h08, 8'h59);
    end
  endtask
  task t_select;
    begin
      @(posedge clk);
      sel <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(word_act, 24'h75a54e, "word_b_sel");
      sel <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(word_act, word_a, "word_a_sel");
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_defaults;
    t_write_all;
    t_bias;
    t_path;
    t_cfg_reset;
    t_hold;
    t_select;
    stop_test;
  end
  // Whole run is under a hundred cycles; this leaves ample margin
  initial
  begin
    #100000;
    fail_count = fail_count + 1;
    stop_test;
  end
endmodule // transceiver_synth_bias_config_regs_tb
